/* File: power_reduction_mode_ctrl.sv */
// Purpose: Power reduction mode controller: mode decode, wake gating, oscillator restart.
// Assumes: Register port strobes are one cycle, never together; inputs synchronous.
// Notes:   The system clock here stays alive; gating is reported on the control outputs.
`timescale 1ns/1ps
module power_reduction_mode_ctrl (
  // Clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          reset_i,
  // Register port
  input  wire pwr_mode_pkg::reg_req_t        req_i,
  output logic [pwr_mode_pkg::DATA_W-1:0]    rdata_o,
  // Wake requests and enables
  input  wire logic [pwr_mode_pkg::WK_N-1:0] wake_irq_i,
  input  wire logic [pwr_mode_pkg::WK_N-1:0] wake_ien_i,
  input  wire logic                          bo_detect_i,
  input  wire logic                          reset_wake_i,
  // Power control outputs
  output pwr_mode_pkg::pwr_ctl_t             pwr_ctl_o,
  output logic                               bo_reset_o,
  output logic                               bo_irq_o,
  output logic                               osc_stable_o
);
  import pwr_mode_pkg::*;

  typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_DOWN, ST_WAKE} pwr_state_t;

  logic [DATA_W-1:0] power_control_reg_r;
  logic [DATA_W-1:0] peripheral_power_reg_r;
  logic [DATA_W-1:0] interrupt_enable_reg0_r;
  logic [DATA_W-1:0] watchdog_control_reg_r;
  logic [DATA_W-1:0] clk_cfg_r;
  pwr_state_t        state_r;
  pwr_mode_t         mode;
  logic [STAB_W-1:0] stab_cnt_r;
  logic              total_r;
  logic [WK_N-1:0]   wake_src;
  logic              irq_wake;
  logic              any_wake;
  logic              wake_clear;
  logic              global_interrupt_enable;
  logic              bo_active;

  // Wake source groups used by the checks below.
  localparam logic [WK_N-1:0] WAKE_ALWAYS    = WK_N'((1 << WK_EXT0) | (1 << WK_EXT1)
                                               | (1 << WK_KBD) | (1 << WK_RTC));
  localparam logic [WK_N-1:0] WAKE_TOTAL_OFF = WK_N'((1 << WK_BO) | (1 << WK_CMP));
  localparam logic [WK_N-1:0] WAKE_WDT       = WK_N'(1 << WK_WDT);

  function automatic logic rc_kept(input logic [DATA_W-1:0] cc);
    rc_kept = cc[CC_RC_SYS] & cc[CC_RTC_EN];
  endfunction : rc_kept

  assign mode = pwr_mode_t'(power_control_reg_r[PC_MODE_HI:PC_MODE_LO]);
  assign global_interrupt_enable = interrupt_enable_reg0_r[IE_GLOBAL];

  // Brownout runs unless powered down, not fitted, or in total power-down.
  assign bo_active = clk_cfg_r[CC_BO_EN] & ~power_control_reg_r[PC_BO_PD]
                     & (mode != MODE_TOTAL);

  always_comb begin
    wake_src = wake_irq_i & wake_ien_i;
    if (total_r) begin
      wake_src[WK_BO]  = 1'b0;
      wake_src[WK_CMP] = 1'b0;
    end
    if (!watchdog_control_reg_r[WD_CLKSEL] && state_r == ST_DOWN) begin
      wake_src[WK_WDT] = 1'b0;
    end
  end

  // Idle accepts any enabled interrupt, power-down only the listed ones.
  assign irq_wake   = global_interrupt_enable & (|wake_src);
  assign any_wake   = irq_wake | reset_wake_i;
  assign wake_clear = ((state_r == ST_IDLE) || (state_r == ST_DOWN)) && any_wake;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_r    <= ST_RUN;
      stab_cnt_r <= '0;
      total_r    <= 1'b0;
    end else begin
      case (state_r)
        ST_RUN: begin
          if (mode == MODE_IDLE) begin
            state_r <= ST_IDLE;
          end else if (mode == MODE_PDOWN || mode == MODE_TOTAL) begin
            state_r <= ST_DOWN;
            total_r <= (mode == MODE_TOTAL);
          end
        end
        ST_IDLE: begin
          if (any_wake) begin
            state_r <= ST_RUN;
          end
        end
        ST_DOWN: begin
          if (any_wake) begin
            state_r    <= ST_WAKE;
            stab_cnt_r <= clk_cfg_r[CC_XTAL] ? XTAL_STAB_N : RC_STAB_N;
          end
        end
        ST_WAKE: begin
          if (stab_cnt_r == STAB_ONE) begin
            state_r <= ST_RUN;
            total_r <= 1'b0;
          end
          stab_cnt_r <= stab_cnt_r - STAB_ONE;
        end
        default: begin
          state_r <= ST_RUN;
        end
      endcase
    end
  end

  // Registers; a wake clears the mode field, overriding a same-cycle write.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      power_control_reg_r     <= REG_RESET;
      peripheral_power_reg_r  <= REG_RESET;
      interrupt_enable_reg0_r <= REG_RESET;
      watchdog_control_reg_r  <= REG_RESET;
      clk_cfg_r               <= REG_RESET;
    end else begin
      if (req_i.wr) begin
        case (req_i.addr)
          OFS_PCTRL:  power_control_reg_r     <= req_i.wdata;
          OFS_PERIPH: peripheral_power_reg_r  <= req_i.wdata;
          OFS_INTERRUPT_ENABLE_REG0:   interrupt_enable_reg0_r <= req_i.wdata;
          OFS_WDCTL:  watchdog_control_reg_r  <= req_i.wdata;
          OFS_CLKCFG: clk_cfg_r               <= req_i.wdata;
          default: begin
          end
        endcase
      end
      if (wake_clear) begin
        power_control_reg_r[PC_MODE_HI:PC_MODE_LO] <= MODE_NORMAL;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_o <= '0;
    end else if (req_i.rd) begin
      case (req_i.addr)
        OFS_PCTRL:  rdata_o <= power_control_reg_r;
        OFS_PERIPH: rdata_o <= peripheral_power_reg_r;
        OFS_INTERRUPT_ENABLE_REG0:   rdata_o <= interrupt_enable_reg0_r;
        OFS_WDCTL:  rdata_o <= watchdog_control_reg_r;
        OFS_CLKCFG: rdata_o <= clk_cfg_r;
        OFS_STATUS: rdata_o <= {4'h0, osc_stable_o, total_r, state_r};
        default:    rdata_o <= '0;
      endcase
    end else begin
      rdata_o <= '0;
    end
  end

  // Control outputs, registered so downstream gating never glitches.
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      pwr_ctl_o    <= '1;
      bo_reset_o   <= 1'b0;
      bo_irq_o     <= 1'b0;
      osc_stable_o <= 1'b1;
    end else begin
      pwr_ctl_o.cpu_run        <= (state_r == ST_RUN) && (mode == MODE_NORMAL);
      pwr_ctl_o.periph_clk_run <= (state_r == ST_RUN) || (state_r == ST_IDLE);
      pwr_ctl_o.core_clk_run   <= (state_r != ST_DOWN);
      pwr_ctl_o.sys_osc_run    <= (state_r != ST_DOWN);
      pwr_ctl_o.rc_osc_run     <= (state_r != ST_DOWN) || rc_kept(clk_cfg_r);
      pwr_ctl_o.bo_det_run     <= bo_active && !(state_r == ST_DOWN && total_r);
      pwr_ctl_o.wdt_run        <= (state_r != ST_DOWN)
                                  || watchdog_control_reg_r[WD_CLKSEL];
      pwr_ctl_o.cmp_run        <= (state_r != ST_DOWN) ? clk_cfg_r[CC_CMP_EN]
                                  : (!total_r && !(peripheral_power_reg_r[PA_VC_PD]
                                  && !clk_cfg_r[CC_CMP_EN]));
      pwr_ctl_o.rtc_run        <= clk_cfg_r[CC_RTC_EN] && !((state_r == ST_DOWN)
                                  && peripheral_power_reg_r[PA_RTC_PD]);
      pwr_ctl_o.ram_retain     <= 1'b1;
      bo_reset_o   <= bo_active && !(state_r == ST_DOWN && total_r)
                      && bo_detect_i && !power_control_reg_r[PC_BO_INT];
      bo_irq_o     <= bo_active && !(state_r == ST_DOWN && total_r) && bo_detect_i
                      && power_control_reg_r[PC_BO_INT]
                      && interrupt_enable_reg0_r[IE_EBO];
      osc_stable_o <= (state_r == ST_RUN) || (state_r == ST_IDLE);
    end
  end

  sequence down_then_wake_s;
    (state_r == ST_DOWN) && any_wake;
  endsequence

  wake_to_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    down_then_wake_s |=> (state_r == ST_WAKE))
    else $error("Wake from power-down did not start stabilisation.");

  xtal_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (down_then_wake_s and clk_cfg_r[CC_XTAL]) |=> (stab_cnt_r == XTAL_STAB_N))
    else $error("Crystal stabilisation count wrong.");

  rc_count_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (down_then_wake_s and !clk_cfg_r[CC_XTAL]) |=> (stab_cnt_r == RC_STAB_N))
    else $error("RC stabilisation count wrong.");

  mode_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    wake_clear |=> (mode == MODE_NORMAL))
    else $error("Mode field not cleared on wake.");

  idle_exit_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_IDLE) && any_wake |=> (state_r == ST_RUN))
    else $error("Idle not left on wake.");

  no_wake_gie_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !global_interrupt_enable && !reset_wake_i |=> (state_r == ST_DOWN))
    else $error("Woke without global enable.");

  idle_cpu_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_IDLE) |=> !pwr_ctl_o.cpu_run && pwr_ctl_o.periph_clk_run)
    else $error("Idle outputs wrong.");

  down_osc_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) |=> !pwr_ctl_o.sys_osc_run && !pwr_ctl_o.core_clk_run)
    else $error("Oscillator running in power-down.");

  total_bo_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && total_r |=> !bo_reset_o && !bo_irq_o)
    else $error("Brownout event in total power-down.");

  total_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && total_r && !reset_wake_i
    && ((wake_irq_i & wake_ien_i & ~WAKE_TOTAL_OFF) == '0) |=> (state_r == ST_DOWN))
    else $error("Excluded wake source accepted.");

  sequence idle_then_wake_s;
    (state_r == ST_IDLE) && any_wake;
  endsequence

  sequence count_done_s;
    (state_r == ST_WAKE) && (stab_cnt_r == STAB_ONE);
  endsequence

  idle_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    idle_then_wake_s |=> (state_r == ST_RUN) ##1 pwr_ctl_o.cpu_run)
    else $error("Processor not resumed after idle wake.");

  norm_run_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) && (mode == MODE_NORMAL)
    |=> pwr_ctl_o.cpu_run && pwr_ctl_o.core_clk_run && pwr_ctl_o.sys_osc_run)
    else $error("Normal operation not fully running.");

  idle_entry_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) && (mode == MODE_IDLE) |=> (state_r == ST_IDLE))
    else $error("Idle mode not entered.");

  pdown_entry_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) && (mode == MODE_PDOWN) |=> (state_r == ST_DOWN) && !total_r)
    else $error("Power-down not entered.");

  total_entry_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) && (mode == MODE_TOTAL) |=> (state_r == ST_DOWN) && total_r)
    else $error("Total power-down not entered.");

  idle_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_IDLE) && !any_wake |=> (state_r == ST_IDLE))
    else $error("Idle left without a wake.");

  down_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !any_wake |=> (state_r == ST_DOWN))
    else $error("Power-down left without a wake.");

  reset_exit_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && reset_wake_i |=> (state_r == ST_WAKE))
    else $error("Enabled reset did not wake power-down.");

  pin_wake_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && global_interrupt_enable
    && |(wake_irq_i & wake_ien_i & WAKE_ALWAYS) |=> (state_r == ST_WAKE))
    else $error("Enabled interrupt did not wake power-down.");

  wdt_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !watchdog_control_reg_r[WD_CLKSEL] && !reset_wake_i
    && ((wake_irq_i & wake_ien_i & ~WAKE_WDT) == '0) |=> (state_r == ST_DOWN))
    else $error("Stopped watchdog woke power-down.");

  wake_osc_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_WAKE) |=> pwr_ctl_o.sys_osc_run && pwr_ctl_o.core_clk_run
    && !pwr_ctl_o.cpu_run && !osc_stable_o)
    else $error("Restart outputs wrong.");

  count_end_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    count_done_s |=> (state_r == ST_RUN) ##1 osc_stable_o)
    else $error("Execution not resumed after stabilisation.");

  count_step_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_WAKE) && (stab_cnt_r != STAB_ONE)
    |=> (state_r == ST_WAKE) && (stab_cnt_r == $past(stab_cnt_r) - STAB_ONE))
    else $error("Stabilisation count skipped.");

  run_stable_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) |=> osc_stable_o)
    else $error("Oscillator not stable while running.");

  down_unstable_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) |=> !osc_stable_o)
    else $error("Oscillator stable in power-down.");

  down_halt_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) |=> !pwr_ctl_o.cpu_run && !pwr_ctl_o.periph_clk_run)
    else $error("Clocks running in power-down.");

  rc_off_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !rc_kept(clk_cfg_r) |=> !pwr_ctl_o.rc_osc_run)
    else $error("RC oscillator left running.");

  rc_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && rc_kept(clk_cfg_r) |=> pwr_ctl_o.rc_osc_run)
    else $error("RC oscillator stopped while clocking the RTC.");

  bo_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !total_r && bo_active |=> pwr_ctl_o.bo_det_run)
    else $error("Brownout detection stopped in power-down.");

  bo_total_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && total_r |=> !pwr_ctl_o.bo_det_run && !pwr_ctl_o.cmp_run)
    else $error("Brownout or comparators on in total power-down.");

  wdt_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && watchdog_control_reg_r[WD_CLKSEL] |=> pwr_ctl_o.wdt_run)
    else $error("Watchdog stopped in power-down.");

  wdt_stop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !watchdog_control_reg_r[WD_CLKSEL] |=> !pwr_ctl_o.wdt_run)
    else $error("Watchdog running in power-down.");

  cmp_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && !total_r && !peripheral_power_reg_r[PA_VC_PD]
    |=> pwr_ctl_o.cmp_run)
    else $error("Comparators stopped in power-down.");

  rtc_pd_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && peripheral_power_reg_r[PA_RTC_PD] |=> !pwr_ctl_o.rtc_run)
    else $error("RTC running although powered down.");

  rtc_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) && clk_cfg_r[CC_RTC_EN]
    && !peripheral_power_reg_r[PA_RTC_PD] |=> pwr_ctl_o.rtc_run)
    else $error("RTC stopped in power-down.");

  ram_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_DOWN) |=> pwr_ctl_o.ram_retain)
    else $error("RAM not retained in power-down.");

  bo_reset_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_r == ST_RUN) && bo_active && bo_detect_i
    && !power_control_reg_r[PC_BO_INT] |=> bo_reset_o)
    else $error("Brownout reset not raised.");

endmodule : power_reduction_mode_ctrl

/* File: pwr_mode_pkg.sv */
// Purpose: Shared constants and types for the power reduction mode controller.
// Assumes: Single system clock at 250 MHz; register port with one-cycle read latency.
// Notes:   Offsets are word indices on the plain register port.
package pwr_mode_pkg;

  // Power mode field encodings.
  typedef enum logic [1:0] {
    MODE_NORMAL  = 2'h0,
    MODE_IDLE    = 2'h1,
    MODE_PDOWN   = 2'h2,
    MODE_TOTAL   = 2'h3
  } pwr_mode_t;

  localparam int          ADDR_W          = 4;
  localparam int          DATA_W          = 8;
  localparam logic [3:0]  OFS_PCTRL       = 4'h0;
  localparam logic [3:0]  OFS_PERIPH      = 4'h1;
  localparam logic [3:0]  OFS_INTERRUPT_ENABLE_REG0        = 4'h2;
  localparam logic [3:0]  OFS_WDCTL       = 4'h3;
  localparam logic [3:0]  OFS_CLKCFG      = 4'h4;
  localparam logic [3:0]  OFS_STATUS      = 4'h5;

  // Field positions.
  localparam int          PC_MODE_LO      = 0;
  localparam int          PC_MODE_HI      = 1;
  localparam int          PC_BO_INT       = 4;
  localparam int          PC_BO_PD        = 5;
  localparam int          PA_VC_PD        = 5;
  localparam int          PA_RTC_PD       = 7;
  localparam int          IE_EBO          = 5;
  localparam int          IE_GLOBAL       = 7;
  localparam int          WD_CLKSEL       = 0;
  localparam int          CC_XTAL         = 0;
  localparam int          CC_RC_SYS       = 1;
  localparam int          CC_RTC_EN       = 2;
  localparam int          CC_CMP_EN       = 3;
  localparam int          CC_BO_EN        = 4;

  localparam logic [7:0]  REG_RESET       = 8'h00;

  // Oscillator stabilisation counts.
  localparam int          XTAL_STAB_CLK   = 1024;
  localparam int          RC_STAB_CLK     = 256;
  localparam int          STAB_W          = 11;
  localparam logic [10:0] XTAL_STAB_N     = 11'(XTAL_STAB_CLK);
  localparam logic [10:0] RC_STAB_N       = 11'(RC_STAB_CLK);
  localparam logic [10:0] STAB_ONE        = 11'h001;

  // Wake source vector positions.
  localparam int          WK_EXT0         = 0;
  localparam int          WK_EXT1         = 1;
  localparam int          WK_BO           = 2;
  localparam int          WK_KBD          = 3;
  localparam int          WK_RTC          = 4;
  localparam int          WK_WDT          = 5;
  localparam int          WK_CMP          = 6;
  localparam int          WK_N            = 7;

  typedef struct packed {
    logic core_clk_run;
    logic cpu_run;
    logic periph_clk_run;
    logic sys_osc_run;
    logic rc_osc_run;
    logic bo_det_run;
    logic wdt_run;
    logic cmp_run;
    logic rtc_run;
    logic ram_retain;
  } pwr_ctl_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage : pwr_mode_pkg

/* File: test_power_reduction_mode_ctrl.sv */
// Purpose: Self-checking bench for the power reduction mode controller.
// Assumes: Register port answers a read one cycle later.
// Notes:   Wake delays are measured as the cycles osc_stable_o stays low.
`timescale 1ns/1ps
module test_power_reduction_mode_ctrl;
  import pwr_mode_pkg::*;
  logic              mclk_i = 1'b0;
  logic              reset_i = 1'b1;
  reg_req_t          req_i = '0;
  logic [DATA_W-1:0] rdata_o;
  logic [WK_N-1:0]   wake_irq_i;
  logic [WK_N-1:0]   wake_ien_i;
  logic              bo_detect_i;
  logic              reset_wake_i;
  pwr_ctl_t          pwr_ctl_o;
  logic              bo_reset_o;
  logic              bo_irq_o;
  logic              osc_stable_o;
  int                num_errors = 0;
  int                cmp_count = 0;
  int                cycles = 0;
  int                len;
  int                srcs[4] = '{WK_EXT0, WK_EXT1, WK_KBD, WK_RTC};
  int                stab_q[$] = '{RC_STAB_CLK, XTAL_STAB_CLK};
  logic [31:0]       seed = 32'h0000E1D7;
  logic [7:0]        rd_v;
  logic              tot;

  power_reduction_mode_ctrl DUT (.mclk_i(mclk_i), .reset_i(reset_i), .req_i(req_i),
    .rdata_o(rdata_o), .wake_irq_i(wake_irq_i), .wake_ien_i(wake_ien_i),
    .bo_detect_i(bo_detect_i), .reset_wake_i(reset_wake_i), .pwr_ctl_o(pwr_ctl_o),
    .bo_reset_o(bo_reset_o), .bo_irq_o(bo_irq_o), .osc_stable_o(osc_stable_o));
  wake_src_model src_m (.mclk_i(mclk_i), .wake_irq_o(wake_irq_i), .wake_ien_o(wake_ien_i),
    .bo_detect_o(bo_detect_i), .reset_wake_o(reset_wake_i));

  always #2 mclk_i = ~mclk_i;
  // The longest run is two restarts plus register traffic, far below this ceiling.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    req_i.addr  <= a;
    req_i.wdata <= d;
    req_i.wr    <= 1'b1;
    @(posedge mclk_i);
    req_i.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk_i);
    req_i.addr <= a;
    req_i.rd   <= 1'b1;
    @(posedge mclk_i);
    req_i.rd <= 1'b0;
    #1 rd_v = rdata_o;
  endtask : rd
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chk1(input string n, input logic e, input logic g);
    chk8(n, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    for (int a = 0; a < 7; a++) begin
      rd(4'(a));
      chk8("reset reg", (a == 5) ? 8'h08 : 8'h00, rd_v);
    end
    $display("test reset done");
    wr(OFS_PCTRL, {6'h00, MODE_IDLE});
    rd(OFS_STATUS);
    chk8("idle state", 8'h01, rd_v & 8'h03);
    chk1("idle cpu", 1'b0, pwr_ctl_o.cpu_run);
    chk1("idle periph", 1'b1, pwr_ctl_o.periph_clk_run);
    src_m.raise(WK_KBD, 1'b1);
    repeat (10) @(posedge mclk_i);
    #1 chk1("no global", 1'b0, pwr_ctl_o.cpu_run);
    src_m.raise_reset();
    repeat (4) @(posedge mclk_i);
    #1 chk1("idle wake", 1'b1, pwr_ctl_o.cpu_run);
    src_m.clear_all();
    rd(OFS_PCTRL);
    chk8("idle mode back", 8'h00, rd_v & 8'h03);
    $display("test idle done");
    wr(OFS_INTERRUPT_ENABLE_REG0, 8'h80);
    for (int c = 0; c < 2; c++) begin
      tot = (c == 1);
      wr(OFS_CLKCFG, tot ? 8'h19 : 8'h1E);
      wr(OFS_PCTRL, {6'h00, tot ? MODE_TOTAL : MODE_PDOWN});
      rd(OFS_STATUS);
      chk8("down state", 8'h02, rd_v & 8'h03);
      chk1("sys osc", 1'b0, pwr_ctl_o.sys_osc_run);
      chk1("core clk", 1'b0, pwr_ctl_o.core_clk_run);
      chk1("ram", 1'b1, pwr_ctl_o.ram_retain);
      chk1("down cpu", 1'b0, pwr_ctl_o.cpu_run);
      chk1("down periph", 1'b0, pwr_ctl_o.periph_clk_run);
      chk1("wdt", 1'b0, pwr_ctl_o.wdt_run);
      chk1("bo det", !tot, pwr_ctl_o.bo_det_run);
      chk1("cmp", !tot, pwr_ctl_o.cmp_run);
      chk1("rc osc", !tot, pwr_ctl_o.rc_osc_run);
      chk1("rtc", !tot, pwr_ctl_o.rtc_run);
      if (tot) begin
        src_m.raise(WK_BO, 1'b1);
        src_m.raise(WK_CMP, 1'b1);
        repeat (10) @(posedge mclk_i);
        #1 chk1("bo cmp wake", 1'b0, pwr_ctl_o.cpu_run);
        chk1("bo reset", 1'b0, bo_reset_o);
        chk1("bo irq", 1'b0, bo_irq_o);
      end
      seed = xs(seed);
      src_m.raise(srcs[seed[1:0]], 1'b1);
      len = 0;
      for (int i = 0; i < 10 && osc_stable_o !== 1'b0; i++) @(posedge mclk_i);
      while (osc_stable_o === 1'b0 && len < 2000) begin
        @(posedge mclk_i);
        #1 len++;
      end
      chk1("stab count", 1'b1, len >= stab_q[c] && len <= stab_q[c] + 2);
      repeat (2) @(posedge mclk_i);
      #1 chk1("cpu resumed", 1'b1, pwr_ctl_o.cpu_run);
      src_m.clear_all();
      rd(OFS_PCTRL);
      chk8("down mode back", 8'h00, rd_v & 8'h03);
      $display("test down case %0d done", c);
    end
    wr(OFS_PCTRL, {6'h00, MODE_IDLE});
    src_m.raise(WK_WDT, 1'b1);
    repeat (3) @(posedge mclk_i);
    #1 chk1("idle irq wake", 1'b1, pwr_ctl_o.cpu_run);
    src_m.clear_all();
    rd(OFS_PCTRL);
    chk8("idle irq mode", 8'h00, rd_v & 8'h03);
    $display("test idle interrupt done");
    src_m.raise(WK_BO, 1'b0);
    repeat (2) @(posedge mclk_i);
    #1 chk1("bo reset run", 1'b1, bo_reset_o);
    wr(OFS_PCTRL, 8'h10);
    wr(OFS_INTERRUPT_ENABLE_REG0, 8'hA0);
    repeat (2) @(posedge mclk_i);
    #1 chk1("bo irq run", 1'b1, bo_irq_o);
    chk1("bo no reset", 1'b0, bo_reset_o);
    src_m.clear_all();
    $display("test brownout done");
    complete_run();
  end
endmodule : test_power_reduction_mode_ctrl

/* File: wake_src_model.sv */
// Purpose: Model of the wake sources and enables beside the mode controller.
// Assumes: Levels change just after a rising clock edge.
// Notes:   Requests stay up as levels until cleared, never as edges.
`timescale 1ns/1ps
module wake_src_model (
  // Clock
  input  wire logic                          mclk_i,
  // Wake side
  output logic [pwr_mode_pkg::WK_N-1:0]      wake_irq_o,
  output logic [pwr_mode_pkg::WK_N-1:0]      wake_ien_o,
  output logic                               bo_detect_o,
  output logic                               reset_wake_o
);
  import pwr_mode_pkg::*;
  initial begin
    wake_irq_o   = '0;
    wake_ien_o   = '0;
    bo_detect_o  = 1'b0;
    reset_wake_o = 1'b0;
  end
  task automatic raise(input int src, input logic en);
    @(posedge mclk_i);
    wake_irq_o[src] <= 1'b1;
    wake_ien_o[src] <= en;
    if (src == WK_BO) begin
      bo_detect_o <= 1'b1;
    end
  endtask : raise
  // A reset request is held until cleared, as the keep-alive supply case needs.
  task automatic raise_reset();
    @(posedge mclk_i);
    reset_wake_o <= 1'b1;
  endtask : raise_reset
  task automatic clear_all();
    @(posedge mclk_i);
    wake_irq_o   <= '0;
    wake_ien_o   <= '0;
    bo_detect_o  <= 1'b0;
    reset_wake_o <= 1'b0;
  endtask : clear_all
endmodule : wake_src_model
